// File: rtl/rvc_pkg.sv
package rvc_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] RVC_REGULATOR_CONTROL_ADDR = 8'hC9;
  localparam logic [7:0] RVC_REGULATOR_CONTROL_RST  = 8'h00;
  localparam int         RVC_OFF_BIT                = 7;
  localparam int         RVC_SENSE_BIT              = 6;
  localparam int         RVC_POL_BIT                = 5;
  localparam int         RVC_LP_BIT                 = 4;

  // ----------------------------------------------------------------
  // Special function register access
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } rvc_sfr_req_s;

endpackage : rvc_pkg

// File: rtl/rvc_regulator_vbus_control.sv
`timescale 1ns/10ps
`default_nettype none
module rvc_regulator_vbus_control
  import rvc_pkg::*;
(
  // Clock and reset
  input  wire logic         mclk,
  input  wire logic         arst_n,
  // Special function register port
  input  wire rvc_sfr_req_s sfr_req,
  output var  logic [7:0]   sfr_rdata,
  // Supply sense pin and reset source select
  input  wire logic         supply_sense_pin,
  input  wire logic         usb_reset_src_en,
  // Regulator and system controls
  output var  logic         regulator_off,
  output var  logic         regulator_low_power_sel,
  output var  logic         supply_irq,
  output var  logic         usb_sys_reset_req
);

  // ----------------------------------------------------------------
  // Sense synchroniser
  // ----------------------------------------------------------------
  logic [1:0] sync_q;
  logic [1:0] sync_d;

  always_comb begin
    sync_d = {sync_q[0], supply_sense_pin};
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      sync_q <= 2'h0;
    end else begin
      sync_q <= sync_d;
    end
  end

  wire logic sense_s = sync_q[1];

  // ----------------------------------------------------------------
  // Register decode
  // ----------------------------------------------------------------
  logic hit;
  logic wr_hit;
  logic rd_hit;

  always_comb begin
    hit    = sfr_req.addr == RVC_REGULATOR_CONTROL_ADDR;
    wr_hit = sfr_req.wr && hit;
    rd_hit = sfr_req.rd && hit;
  end

  // ----------------------------------------------------------------
  // Control bits
  // ----------------------------------------------------------------
  logic off_q;
  logic off_d;
  logic pol_q;
  logic pol_d;
  logic lp_q;
  logic lp_d;

  always_comb begin
    off_d = off_q;
    pol_d = pol_q;
    lp_d  = lp_q;
    if (wr_hit) begin
      off_d = sfr_req.wdata[RVC_OFF_BIT];
      pol_d = sfr_req.wdata[RVC_POL_BIT];
      lp_d  = sfr_req.wdata[RVC_LP_BIT];
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      off_q <= RVC_REGULATOR_CONTROL_RST[RVC_OFF_BIT];
      pol_q <= RVC_REGULATOR_CONTROL_RST[RVC_POL_BIT];
      lp_q  <= RVC_REGULATOR_CONTROL_RST[RVC_LP_BIT];
    end else begin
      off_q <= off_d;
      pol_q <= pol_d;
      lp_q  <= lp_d;
    end
  end

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;

  always_comb begin
    rdata_d = 8'h00; // Reserved bits and misses read zero
    if (rd_hit) begin
      rdata_d[RVC_OFF_BIT]   = off_q;
      rdata_d[RVC_SENSE_BIT] = sense_s;
      rdata_d[RVC_POL_BIT]   = pol_q;
      rdata_d[RVC_LP_BIT]    = lp_q;
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rdata_q <= RVC_REGULATOR_CONTROL_RST;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  // ----------------------------------------------------------------
  // Supply interrupt and reset request
  // ----------------------------------------------------------------
  logic match;
  logic irq_q;
  logic irq_d;
  logic rst_q;
  logic rst_d;

  always_comb begin
    match = sense_s == pol_q;
    irq_d = match;
    rst_d = match && usb_reset_src_en;
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      irq_q <= 1'b0;
      rst_q <= 1'b0;
    end else begin
      irq_q <= irq_d;
      rst_q <= rst_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------

  always_comb begin
    sfr_rdata               = rdata_q;
    regulator_off           = off_q;
    regulator_low_power_sel = lp_q;
    supply_irq              = irq_q;
    usb_sys_reset_req       = rst_q;
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);

  write_off_a: assert property (sfr_req.wr && hit |=>
    regulator_off == $past(sfr_req.wdata[RVC_OFF_BIT]))
    else $error("regulator off bit not written");
  write_lp_a: assert property (sfr_req.wr && hit |=>
    regulator_low_power_sel == $past(sfr_req.wdata[RVC_LP_BIT]))
    else $error("low power select not written");
  hold_mode_a: assert property (!(sfr_req.wr && hit) |=>
    $stable(regulator_low_power_sel))
    else $error("mode changed without write");
  sense_read_a: assert property (sfr_req.rd && hit |=>
    sfr_rdata[RVC_SENSE_BIT] == $past(sense_s))
    else $error("sense bit read wrong");
  live_sense_a: assert property ($rose(sync_q[1]) ##0 (sfr_req.rd && hit)
    |=> sfr_rdata[RVC_SENSE_BIT])
    else $error("sense bit not live");
  reserved_zero_a: assert property (sfr_rdata[3:0] == 4'h0)
    else $error("reserved bits nonzero");
  irq_level_a: assert property ($past(arst_n) |->
    supply_irq == ($past(sense_s) == $past(pol_q)))
    else $error("interrupt level wrong");
  pol_low_a: assert property (!pol_q && !sense_s |=> supply_irq)
    else $error("active low polarity failed");
  reset_req_a: assert property ($past(arst_n) |->
    usb_sys_reset_req == ($past(match) && $past(usb_reset_src_en)))
    else $error("reset request wrong");

  // ----------------------------------------------------------------
  // Further access and supply checks
  // ----------------------------------------------------------------
  write_pol_a: assert property (sfr_req.wr && hit |=>
    pol_q == $past(sfr_req.wdata[RVC_POL_BIT]))
    else $error("interrupt polarity not written");
  hold_ctrl_a: assert property (!(sfr_req.wr && hit) |=>
    $stable(regulator_off) && $stable(pol_q))
    else $error("control bit changed without write");
  read_ctrl_a: assert property (sfr_req.rd && hit |=>
    sfr_rdata[RVC_OFF_BIT] == $past(regulator_off) &&
    sfr_rdata[RVC_POL_BIT] == $past(pol_q) &&
    sfr_rdata[RVC_LP_BIT] == $past(regulator_low_power_sel))
    else $error("control bits read wrong");
  read_miss_a: assert property (!(sfr_req.rd && hit) |=>
    sfr_rdata == 8'h00)
    else $error("read data without a read");
  reset_clear_a: assert property ($rose(arst_n) |->
    sfr_rdata == 8'h00 && !regulator_off && !regulator_low_power_sel &&
    !supply_irq && !usb_sys_reset_req)
    else $error("outputs not cleared by reset");
  sense_sync_a: assert property ($past(arst_n, 2) |->
    sense_s == $past(supply_sense_pin, 2))
    else $error("sense synchroniser delay wrong");
  irq_off_a: assert property (pol_q != sense_s |=> !supply_irq)
    else $error("interrupt active without match");
  pol_high_a: assert property (pol_q && sense_s |=> supply_irq)
    else $error("active high polarity failed");
  reset_gate_a: assert property (!usb_reset_src_en |=>
    !usb_sys_reset_req)
    else $error("reset request while source off");
  reset_level_a: assert property (usb_sys_reset_req |-> supply_irq)
    else $error("reset request without match");

  // ----------------------------------------------------------------
  // Cover points
  // ----------------------------------------------------------------
  irq_hi_c:  cover property (pol_q && sense_s ##1 supply_irq);
  irq_lo_c:  cover property (!pol_q && !sense_s ##1 supply_irq);
  rst_c:     cover property (usb_sys_reset_req);
  lp_c:      cover property ($rose(regulator_low_power_sel));
  live_c:    cover property ($rose(sense_s) ##0 (sfr_req.rd && hit));

endmodule : rvc_regulator_vbus_control
`default_nettype wire

// File: tb/regulator_vbus_control_test.sv
`timescale 1ns/10ps
`default_nettype none
module regulator_vbus_control_test;
  import rvc_pkg::*;
  localparam logic [7:0] A = RVC_REGULATOR_CONTROL_ADDR;
  logic mclk = 0, arst_n = 0, attach = 0, src_en = 0, vbus;
  logic off, lp, irq, rreq;
  logic [7:0] rdata;
  rvc_sfr_req_s req = '0;
  int n_errors = 0, n_compared = 0, cyc = 0;
  always #20 mclk = ~mclk;
  rvc_vbus_host host (.attach(attach), .vbus(vbus));
  rvc_regulator_vbus_control DUT (.mclk(mclk), .arst_n(arst_n),
    .sfr_req(req), .sfr_rdata(rdata), .supply_sense_pin(vbus),
    .usb_reset_src_en(src_en), .regulator_off(off),
    .regulator_low_power_sel(lp), .supply_irq(irq),
    .usb_sys_reset_req(rreq));
  // ----
  // Helpers
  // ----
  task automatic chk(logic [7:0] seen, logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : chk
  task automatic acc(logic w, logic [7:0] a, logic [7:0] d);
    @(negedge mclk);
    req = '{w, !w, a, d};
    @(negedge mclk);
    req = '0;
  endtask : acc
  task automatic wrap_up;
    $display("compared %0d, errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : wrap_up
  // ----
  // Scenarios
  // ----
  task automatic t_reset;
    acc(1'b0, A, 8'h00);
    chk(rdata, RVC_REGULATOR_CONTROL_RST);
    chk({4'h0, off, lp, irq, rreq}, 8'h02);
    $display("reset test done");
  endtask : t_reset
  task automatic t_write;
    acc(1'b1, A, 8'hFF);
    chk({6'h00, off, lp}, 8'h03);
    acc(1'b1, 8'hC8, 8'h00);
    acc(1'b0, A, 8'h00);
    chk(rdata, 8'hB0);
    acc(1'b0, 8'hC8, 8'h00);
    chk(rdata, 8'h00);
    $display("write test done");
  endtask : t_write
  task automatic t_sense;
    attach = 1'b1;
    src_en = 1'b1;
    @(negedge mclk);
    acc(1'b0, A, 8'h00);
    chk(rdata, 8'hF0);
    chk({4'h0, off, lp, irq, rreq}, 8'h0F);
    acc(1'b1, A, 8'h00);
    @(negedge mclk);
    chk({4'h0, off, lp, irq, rreq}, 8'h00);
    attach = 1'b0;
    repeat (4) @(negedge mclk);
    chk({6'h00, irq, rreq}, 8'h03);
    acc(1'b0, A, 8'h00);
    chk(rdata, 8'h00);
    $display("sense test done");
  endtask : t_sense
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 400) begin
      n_errors++;
      wrap_up();
    end
  end
  initial begin
    repeat (2) @(negedge mclk);
    arst_n = 1;
    t_reset();
    t_write();
    t_sense();
    wrap_up();
  end
endmodule : regulator_vbus_control_test
`default_nettype wire

// File: tb/rvc_vbus_host.sv
`timescale 1ns/10ps
`default_nettype none
module rvc_vbus_host (
  // Cable state
  input  wire logic attach,
  // Bus supply line
  output var  logic vbus
);
  // Supply present exactly while attached
  always_comb vbus = attach;
endmodule : rvc_vbus_host
`default_nettype wire
